/* File: common/sdpi_init_regs.svh */
/*
 * constants for the memory power-up init link: mode register addresses,
 * field positions, reset values, timing figures and controller register map.
 * assumes: included by bare name from interface, design and bench files.
 */
`ifndef SDPI_INIT_REGS_SVH
`define SDPI_INIT_REGS_SVH

// ----------------------------------------------------------------------------
// clock
// ----------------------------------------------------------------------------
`define SDPI_CLK_PERIOD_NS      100

// ----------------------------------------------------------------------------
// timing figures in their own units, cycle counts derived (least times round up)
// ----------------------------------------------------------------------------
`define SDPI_RESET_HOLD_US      200
`define SDPI_CKE_PRE_REL_NS     10
`define SDPI_CKE_POST_REL_MS    2
`define SDPI_CLK_STABLE_TCK     5
`define SDPI_IDLE_FIRST_US      2
`define SDPI_BOOT_CLK_NS        18
`define SDPI_WARM_RESET_NS      100
`define SDPI_ZQCAL_US           1
`define SDPI_ZQLAT_NS           30
`define SDPI_CEIL_CYC(ns)       (((ns) + `SDPI_CLK_PERIOD_NS - 1) / `SDPI_CLK_PERIOD_NS)
`define SDPI_RESET_HOLD_CYC     `SDPI_CEIL_CYC(`SDPI_RESET_HOLD_US * 1000)
`define SDPI_CKE_PRE_REL_CYC    `SDPI_CEIL_CYC(`SDPI_CKE_PRE_REL_NS)
`define SDPI_CKE_POST_REL_CYC   `SDPI_CEIL_CYC(`SDPI_CKE_POST_REL_MS * 1000000)
`define SDPI_IDLE_FIRST_CYC     `SDPI_CEIL_CYC(`SDPI_IDLE_FIRST_US * 1000)
`define SDPI_WARM_RESET_CYC     `SDPI_CEIL_CYC(`SDPI_WARM_RESET_NS)
`define SDPI_ZQCAL_CYC          `SDPI_CEIL_CYC(`SDPI_ZQCAL_US * 1000)
`define SDPI_ZQLAT_CYC          `SDPI_CEIL_CYC(`SDPI_ZQLAT_NS)

// ----------------------------------------------------------------------------
// mode register addresses (6 bits)
// ----------------------------------------------------------------------------
`define SDPI_MA_FEATURE_ONE     6'h01
`define SDPI_MA_LATENCY_TWO     6'h02
`define SDPI_MA_IO_CONFIG_ONE   6'h03
`define SDPI_MA_TERMINATION     6'h0b
`define SDPI_MA_CMD_REF         6'h0c
`define SDPI_MA_FREQ_SET        6'h0d
`define SDPI_MA_DATA_REF        6'h0e

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define SDPI_LEVELING_BIT       7
`define SDPI_FEATURE_ONE_RST    8'h00
`define SDPI_LATENCY_TWO_RST    8'h00
`define SDPI_IO_CONFIG_ONE_RST  8'h00
`define SDPI_TERMINATION_RST    8'h00
`define SDPI_FREQ_SET_RST       8'h00
`define SDPI_REF_LEVEL_RST      8'h5d
`define SDPI_TRAIN_PATTERN      8'h5a

// ----------------------------------------------------------------------------
// controller register map (software side)
// ----------------------------------------------------------------------------
`define SDPI_CTL_CONTROL        4'h0
`define SDPI_CTL_STATUS         4'h1
`define SDPI_CTL_MRW            4'h2
`define SDPI_CTL_MRR_ADDR       4'h3
`define SDPI_CTL_MRR_DATA       4'h4
`define SDPI_CTL_TRAIN_PAT      4'h5

`endif

/* File: common/sdpi_pkg.sv */
/*
 * types shared by both ends of the init link.
 * assumes: constants come from sdpi_init_regs.svh.
 */
package sdpi_pkg;

   // ----------------------------------------------------------------------------
   // command codes on the simplified command bus
   // ----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      SDPI_CMD_NOP,     // nothing
      SDPI_CMD_MRW,     // mode register write
      SDPI_CMD_MRR,     // mode register read
      SDPI_CMD_ZQ_START, // start impedance calibration
      SDPI_CMD_ZQ_LATCH, // apply calibration result
      SDPI_CMD_CBT,     // command bus training pattern
      SDPI_CMD_MPC_RD,  // read dq calibration pattern
      SDPI_CMD_NORMAL   // any normal command after training
   } sdpi_cmd_t;

   // ----------------------------------------------------------------------------
   // controller sequence steps
   // ----------------------------------------------------------------------------
   typedef enum logic [3:0] {
      SDPI_ST_RESET_HOLD, SDPI_ST_CKE_PRE, SDPI_ST_CKE_WAIT, SDPI_ST_IDLE_WAIT,
      SDPI_ST_READY_MR, SDPI_ST_ZQ_CAL, SDPI_ST_ZQ_LAT, SDPI_ST_TRAINING, SDPI_ST_NORMAL
   } sdpi_step_t;

endpackage : sdpi_pkg

/* File: common/sdpi_link_if.sv */
/*
 * link between controller and memory device init logic.
 * assumes: one clock, both ends on it; dq is driven by the device only, resolved here.
 */
`timescale 1ns/1ps
`include "sdpi_init_regs.svh"

interface sdpi_link_if;
   logic              reset_n;   // active-low memory reset
   logic              cke;       // clock enable
   logic              cs;        // chip select
   logic              ck_run;    // memory clock running
   sdpi_pkg::sdpi_cmd_t cmd;     // command code
   logic [5:0]        ma;        // mode register address / train pattern
   logic [7:0]        op;        // operand
   logic [7:0]        dq_dev_o;  // device drive value
   logic              dq_dev_oe; // device drives dq
   logic [7:0]        dq;        // resolved bus level as seen by controller

   // device has no pull: undriven bus reads zero
   assign dq = dq_dev_oe ? dq_dev_o : 8'h00;

   modport ctrl (output reset_n, output cke, output cs, output ck_run, output cmd, output ma,
                 output op, input dq);
   modport dev  (input reset_n, input cke, input cs, input ck_run, input cmd, input ma,
                 input op, output dq_dev_o, output dq_dev_oe);
endinterface : sdpi_link_if

/* File: hdl/sdpi_device.sv */
/*
 * device end: mode register defaults, reset behaviour and training answers.
 * assumes: controller keeps its timing; link signals are on clk.
 */
`timescale 1ns/1ps
`include "sdpi_init_regs.svh"

module sdpi_device (
   input  wire logic  clk,                 // system clock
   input  wire logic  rst,                 // async reset, active high
   sdpi_link_if.dev   link,                // link to controller
   output logic       leveling_active,     // write leveling mode on
   output logic       calibrated,          // calibration latched into drivers
   output logic       ready_normal,        // normal command seen after init
   output logic [7:0] array_writes         // count of array-changing commands
);
   // ----------------------------------------------------------------------------
   // mode registers
   // ----------------------------------------------------------------------------
   logic [7:0] feature_one_recovery_q;
   logic [7:0] latency_feature_two_q;
   logic [7:0] io_config_one_q;
   logic [7:0] termination_setting_q;
   logic [7:0] command_reference_level_q;
   logic [7:0] frequency_set_control_q;
   logic [7:0] data_reference_level_q;
   logic       zq_running_q;          // calibration started, not latched
   logic       in_reset;               // reset pin low

   assign in_reset = ~link.reset_n;

   // mode register writes; pin reset returns every default [R20]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         feature_one_recovery_q    <= `SDPI_FEATURE_ONE_RST;   // [R01]
         latency_feature_two_q     <= `SDPI_LATENCY_TWO_RST;   // [R01]
         frequency_set_control_q   <= `SDPI_FREQ_SET_RST;      // [R01]
         io_config_one_q           <= `SDPI_IO_CONFIG_ONE_RST; // [R02]
         termination_setting_q     <= `SDPI_TERMINATION_RST;   // [R02]
         command_reference_level_q <= `SDPI_REF_LEVEL_RST;     // [R03]
         data_reference_level_q    <= `SDPI_REF_LEVEL_RST;     // [R03]
      end else if (in_reset) begin // [R20]
         feature_one_recovery_q    <= `SDPI_FEATURE_ONE_RST;
         latency_feature_two_q     <= `SDPI_LATENCY_TWO_RST;
         frequency_set_control_q   <= `SDPI_FREQ_SET_RST;
         io_config_one_q           <= `SDPI_IO_CONFIG_ONE_RST;
         termination_setting_q     <= `SDPI_TERMINATION_RST;
         command_reference_level_q <= `SDPI_REF_LEVEL_RST;
         data_reference_level_q    <= `SDPI_REF_LEVEL_RST;
      end else if (link.cke && link.cmd == sdpi_pkg::SDPI_CMD_MRW) begin
         case (link.ma)
            `SDPI_MA_FEATURE_ONE:   feature_one_recovery_q    <= link.op;
            `SDPI_MA_LATENCY_TWO:   latency_feature_two_q     <= link.op; // [R16]
            `SDPI_MA_IO_CONFIG_ONE: io_config_one_q           <= link.op;
            `SDPI_MA_TERMINATION:   termination_setting_q     <= link.op;
            `SDPI_MA_CMD_REF:       command_reference_level_q <= link.op;
            `SDPI_MA_FREQ_SET:      frequency_set_control_q   <= link.op;
            `SDPI_MA_DATA_REF:      data_reference_level_q    <= link.op;
            default: ;              // unmodelled addresses ignored
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // calibration start/latch
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         zq_running_q <= 1'b0;
         calibrated   <= 1'b0;
      end else if (in_reset) begin
         zq_running_q <= 1'b0;
         calibrated   <= 1'b0;
      end else if (link.cke && link.cmd == sdpi_pkg::SDPI_CMD_ZQ_START) begin
         zq_running_q <= 1'b1;
      end else if (link.cke && link.cmd == sdpi_pkg::SDPI_CMD_ZQ_LATCH && zq_running_q) begin
         zq_running_q <= 1'b0;
         calibrated   <= 1'b1; // latched values now drive dq and termination [R13]
      end
   end

   // ----------------------------------------------------------------------------
   // dq answers: mode register read, bus training echo, read calibration
   // ----------------------------------------------------------------------------
   // outputs stay undriven while reset pin is low [R04]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link.dq_dev_oe <= 1'b0; // [R04]
         link.dq_dev_o  <= 8'h00;
      end else if (in_reset || !link.cke) begin
         link.dq_dev_oe <= 1'b0; // [R04]
         link.dq_dev_o  <= 8'h00;
      end else begin
         case (link.cmd)
            sdpi_pkg::SDPI_CMD_MRR: begin
               link.dq_dev_oe <= 1'b1;
               case (link.ma)
                  `SDPI_MA_CMD_REF:  link.dq_dev_o <= command_reference_level_q;
                  `SDPI_MA_DATA_REF: link.dq_dev_o <= data_reference_level_q;
                  default:           link.dq_dev_o <= 8'h00; // write-only reads zero
               endcase
            end
            sdpi_pkg::SDPI_CMD_CBT: begin
               // pattern from the command-address bits, no strobe involved [R15]
               link.dq_dev_oe <= 1'b1;
               link.dq_dev_o  <= {2'b00, link.ma};
            end
            sdpi_pkg::SDPI_CMD_MPC_RD: begin
               // fixed calibration pattern; array untouched [R17]
               link.dq_dev_oe <= 1'b1;
               link.dq_dev_o  <= `SDPI_TRAIN_PATTERN;
            end
            default: begin
               link.dq_dev_oe <= 1'b0;
               link.dq_dev_o  <= 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // status outputs
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         leveling_active <= 1'b0;
         ready_normal    <= 1'b0;
         array_writes    <= 8'h00;
      end else if (in_reset) begin
         leveling_active <= 1'b0;
         ready_normal    <= 1'b0;
      end else begin
         leveling_active <= latency_feature_two_q[`SDPI_LEVELING_BIT]; // [R16]
         // any valid command is accepted after training [R18]
         if (link.cke && link.cmd == sdpi_pkg::SDPI_CMD_NORMAL) begin
            ready_normal <= 1'b1;
            array_writes <= array_writes + 8'h01; // only normal commands touch the array [R17]
         end
      end
   end
endmodule : sdpi_device

/* File: hdl/sdpi_controller.sv */
/*
 * controller end: power-up / warm-reset init sequencer with software registers.
 * assumes: power is stable when rst falls; device end on the same clock.
 */
`timescale 1ns/1ps
`include "sdpi_init_regs.svh"

// Operation
// R01: device zeroes frequency, latency, recovery fields
// R02: device disables inversion and termination
// R03: reference levels default range one, 011101b
// R04: device outputs undriven while reset low
// R05: reset held 200 us after ramp
// R06: cke low 10 ns before release
// R07: cke low 2 ms after release
// R08: clock runs five cycles before cke
// R09: chip select low when cke rises
// R10: wait 2 us before first mode access
// R11: mode accesses at boot clock rate
// R12: calibration start after drive settings written
// R13: latch after calibration time applies values
// R14: command bus training after latch time
// R15: device echoes training pattern on data
// R16: leveling on feature-two bit seven
// R17: data training leaves array unchanged
// R18: any command accepted after training
// R19: warm reset pulse 100 ns, rerun
// R20: reset pin forces device reset state
// R21: each delay a rounded-up cycle counter
module sdpi_controller #(
   parameter int unsigned RESET_HOLD_CYC = `SDPI_RESET_HOLD_CYC,    // reset hold count
   parameter int unsigned CKE_POST_CYC   = `SDPI_CKE_POST_REL_CYC   // cke wait count
) (
   input  wire logic       clk,         // system clock
   input  wire logic       rst,         // async reset, active high
   sdpi_link_if.ctrl       link,        // link to device
   input  wire logic [3:0] sw_addr,     // register address
   input  wire logic [7:0] sw_wdata,    // write data
   input  wire logic       sw_write,    // write strobe
   input  wire logic       sw_read,     // read strobe
   output logic      [7:0] sw_rdata     // read data, cycle after strobe
);
   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   localparam int unsigned CW = 16;               // counter width
   sdpi_pkg::sdpi_step_t step_q;                  // sequence step
   logic [CW-1:0]        wait_q;                  // delay counter
   logic [2:0]           clk_run_q;               // clock-stable cycles seen
   logic                 cmd_pend_q;              // software command pending
   sdpi_pkg::sdpi_cmd_t  cmd_kind_q;              // pending command
   logic [5:0]           cmd_ma_q;                // pending address
   logic [7:0]           cmd_op_q;                // pending operand
   logic                 mrr_cap_q;               // capture dq next cycle
   logic [7:0]           mrr_data_q;              // last read result
   logic                 warm_q;                  // warm reset request

   // delay load value in cycles, cut to CW bits, zero input loaded as one [R21]
   function automatic logic [CW-1:0] cyc(input int unsigned n);
      cyc = (n == 0) ? CW'(1) : CW'(n);
   endfunction : cyc

   // ----------------------------------------------------------------------------
   // sequencer; each step leaves only when its counter is zero, except on warm reset [R21]
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step_q       <= sdpi_pkg::SDPI_ST_RESET_HOLD;
         wait_q       <= CW'(0);
         link.reset_n <= 1'b0;
         link.cke     <= 1'b0;
         link.cs      <= 1'b0;
         link.ck_run  <= 1'b0;
      end else if (warm_q) begin
         // warm reset: cke driven low, short pulse then rerun from the cke pre step [R19]
         step_q       <= sdpi_pkg::SDPI_ST_CKE_PRE;
         wait_q       <= cyc(`SDPI_WARM_RESET_CYC); // [R19]
         link.reset_n <= 1'b0;
         link.cke     <= 1'b0; // [R06]
         link.cs      <= 1'b0;
      end else if (wait_q != CW'(0)) begin
         wait_q <= wait_q - CW'(1);
      end else begin
         case (step_q)
            sdpi_pkg::SDPI_ST_RESET_HOLD: begin
               step_q <= sdpi_pkg::SDPI_ST_CKE_PRE;
               wait_q <= cyc(RESET_HOLD_CYC); // [R05]
            end
            sdpi_pkg::SDPI_ST_CKE_PRE: begin
               // cke has been low far longer than 10 ns here [R06]
               link.reset_n <= 1'b1;
               step_q       <= sdpi_pkg::SDPI_ST_CKE_WAIT;
               wait_q       <= cyc(CKE_POST_CYC); // [R07]
            end
            sdpi_pkg::SDPI_ST_CKE_WAIT: begin
               link.ck_run <= 1'b1; // clock starts once the wait has ended
               if (clk_run_q == 3'(`SDPI_CLK_STABLE_TCK)) begin // [R08]
                  link.cke <= 1'b1;
                  link.cs  <= 1'b0; // [R09]
                  step_q   <= sdpi_pkg::SDPI_ST_IDLE_WAIT;
                  wait_q   <= cyc(`SDPI_IDLE_FIRST_CYC); // [R10]
               end
            end
            sdpi_pkg::SDPI_ST_IDLE_WAIT: step_q <= sdpi_pkg::SDPI_ST_READY_MR;
            sdpi_pkg::SDPI_ST_READY_MR: begin
               // 100 ns clock is slower than the 18 ns boot limit [R11]
               if (cmd_pend_q && cmd_kind_q == sdpi_pkg::SDPI_CMD_ZQ_START) begin // [R12]
                  step_q <= sdpi_pkg::SDPI_ST_ZQ_CAL;
                  wait_q <= cyc(`SDPI_ZQCAL_CYC);
               end
            end
            sdpi_pkg::SDPI_ST_ZQ_CAL: begin
               step_q <= sdpi_pkg::SDPI_ST_ZQ_LAT; // latch issued on entry [R13]
               wait_q <= cyc(`SDPI_ZQLAT_CYC);
            end
            sdpi_pkg::SDPI_ST_ZQ_LAT: step_q <= sdpi_pkg::SDPI_ST_TRAINING; // [R14]
            sdpi_pkg::SDPI_ST_TRAINING: begin
               if (cmd_pend_q && cmd_kind_q == sdpi_pkg::SDPI_CMD_NORMAL)
                  step_q <= sdpi_pkg::SDPI_ST_NORMAL; // [R18]
            end
            sdpi_pkg::SDPI_ST_NORMAL: step_q <= sdpi_pkg::SDPI_ST_NORMAL;
            default: step_q <= sdpi_pkg::SDPI_ST_RESET_HOLD;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // stable-clock counter, cleared whenever the clock is stopped
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         clk_run_q <= 3'h0;
      else if (!link.ck_run || warm_q)
         clk_run_q <= 3'h0;
      else if (clk_run_q != 3'(`SDPI_CLK_STABLE_TCK))
         clk_run_q <= clk_run_q + 3'h1; // [R08]
   end

   // ----------------------------------------------------------------------------
   // command issue: one cycle on the bus, only in legal steps
   // ----------------------------------------------------------------------------
   logic issue_ok; // pending command may go out this cycle
   always_comb begin
      issue_ok = 1'b0;
      if (cmd_pend_q && wait_q == CW'(0) && !warm_q) begin
         case (step_q)
            sdpi_pkg::SDPI_ST_READY_MR: issue_ok = 1'b1; // [R10]
            sdpi_pkg::SDPI_ST_TRAINING: issue_ok = (cmd_kind_q != sdpi_pkg::SDPI_CMD_ZQ_START);
            sdpi_pkg::SDPI_ST_NORMAL:   issue_ok = 1'b1;
            default:                    issue_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link.cmd <= sdpi_pkg::SDPI_CMD_NOP;
         link.ma  <= 6'h00;
         link.op  <= 8'h00;
      end else if (step_q == sdpi_pkg::SDPI_ST_ZQ_CAL && wait_q == CW'(0) && !warm_q) begin
         link.cmd <= sdpi_pkg::SDPI_CMD_ZQ_LATCH; // [R13]
      end else if (issue_ok) begin
         link.cmd <= cmd_kind_q;
         link.ma  <= cmd_ma_q;
         link.op  <= cmd_op_q;
      end else begin
         link.cmd <= sdpi_pkg::SDPI_CMD_NOP;
      end
   end

   // ----------------------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_pend_q <= 1'b0;
         cmd_kind_q <= sdpi_pkg::SDPI_CMD_NOP;
         cmd_ma_q   <= 6'h00;
         cmd_op_q   <= 8'h00;
         warm_q     <= 1'b0;
      end else begin
         warm_q <= sw_write && sw_addr == `SDPI_CTL_CONTROL && sw_wdata[0];
         if (issue_ok || warm_q)
            cmd_pend_q <= 1'b0;
         if (sw_write && sw_addr == `SDPI_CTL_MRW && !cmd_pend_q) begin
            cmd_pend_q <= 1'b1;
            cmd_kind_q <= sw_wdata[7] ? sdpi_pkg::SDPI_CMD_MRW : sdpi_pkg::sdpi_cmd_t'(sw_wdata[2:0]);
            // address register is kept: reads and training patterns use it [R15]
         end
         if (sw_write && sw_addr == `SDPI_CTL_MRR_ADDR && !cmd_pend_q)
            cmd_ma_q <= sw_wdata[5:0];
         if (sw_write && sw_addr == `SDPI_CTL_TRAIN_PAT && !cmd_pend_q)
            cmd_op_q <= sw_wdata;
      end
   end

   // dq sampled the cycle after a read-type command leaves
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mrr_cap_q  <= 1'b0;
         mrr_data_q <= 8'h00;
      end else begin
         mrr_cap_q <= link.cmd == sdpi_pkg::SDPI_CMD_MRR || link.cmd == sdpi_pkg::SDPI_CMD_CBT
                      || link.cmd == sdpi_pkg::SDPI_CMD_MPC_RD;
         if (mrr_cap_q)
            mrr_data_q <= link.dq;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         sw_rdata <= 8'h00;
      else if (sw_read) begin
         case (sw_addr)
            `SDPI_CTL_STATUS:   sw_rdata <= {3'h0, cmd_pend_q, 4'(step_q)};
            `SDPI_CTL_MRR_ADDR: sw_rdata <= {2'h0, cmd_ma_q};
            `SDPI_CTL_MRR_DATA: sw_rdata <= mrr_data_q;
            `SDPI_CTL_TRAIN_PAT: sw_rdata <= cmd_op_q;
            default:            sw_rdata <= 8'h00;
         endcase
      end else
         sw_rdata <= 8'h00;
   end
endmodule : sdpi_controller

/* File: dv/sdpi_init_assertions.sv */
/* checker for the init link between controller and device.
   assumes: placed beside the link interface, one clock, rst async high. */
`timescale 1ns/1ps
module sdpi_init_assertions #(
   parameter int unsigned CKE_POST_CYC = 8 // cke wait after reset release
) (
   input logic                clk,       // system clock
   input logic                rst,       // async reset, active high
   input logic                reset_n,   // active-low memory reset
   input logic                cke,       // clock enable
   input logic                cs,        // chip select
   input logic                ck_run,    // memory clock running
   input sdpi_pkg::sdpi_cmd_t cmd,       // command code
   input logic                dq_dev_oe  // device drives dq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // quiet spell after calibration start, no early latch
   sequence s_zq_quiet; (cmd != sdpi_pkg::SDPI_CMD_ZQ_LATCH) [*8]; endsequence
   a_oe_quiet_reset: assert property (!reset_n || !cke |-> !dq_dev_oe) else $error("dq driven in reset");
   a_cke_pre_rel: assert property ($rose(reset_n) |-> !cke && !$past(cke)) else $error("cke high at release");
   a_cke_post_wait: assert property ($rose(cke) |-> $past(reset_n, CKE_POST_CYC))
      else $error("cke too early");
   a_clock_before_cke: assert property ($rose(cke) |-> ck_run && $past(ck_run, 5)) else $error("clock late");
   a_cs_low_cke: assert property ($rose(cke) |-> !cs) else $error("cs high at cke rise");
   a_idle_first_mr: assert property (cmd inside {sdpi_pkg::SDPI_CMD_MRW, sdpi_pkg::SDPI_CMD_MRR}
      |-> $past(cke, 20)) else $error("mode access too soon");
   a_cmd_needs_cke: assert property (cmd != sdpi_pkg::SDPI_CMD_NOP |-> cke && reset_n)
      else $error("cmd with cke low");
   a_zq_latch_time: assert property (cmd == sdpi_pkg::SDPI_CMD_ZQ_START |=> s_zq_quiet
      ##[2:12] (cmd == sdpi_pkg::SDPI_CMD_ZQ_LATCH)) else $error("latch timing wrong");
   a_train_echo: assert property (cmd inside {sdpi_pkg::SDPI_CMD_CBT, sdpi_pkg::SDPI_CMD_MPC_RD}
      |=> dq_dev_oe ##1 !dq_dev_oe) else $error("training answer wrong");
endmodule : sdpi_init_assertions

/* File: dv/testbench.sv */
/* self-checking bench: controller and device joined by the link interface.
   assumes: software port reads answer one cycle after the strobe. */
`timescale 1ns/1ps
`include "sdpi_init_regs.svh"
module testbench;
   logic       clk = 1'b0, rst = 1'b1;            // clock and reset
   logic [3:0] sw_addr = 4'h0;                    // register address
   logic [7:0] sw_wdata = 8'h00, sw_rdata, rd;    // data paths
   logic       sw_write = 1'b0, sw_read = 1'b0;   // strobes
   logic       lev, cal, rdy;                     // device status
   logic [7:0] aw;                                // array change count
   int         n_errors = 0, n_tests = 0;         // tallies
   sdpi_link_if link_i ();
   sdpi_controller #(.RESET_HOLD_CYC(4), .CKE_POST_CYC(8)) sdpi_controller_i (.clk(clk), .rst(rst), .link(link_i),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata));
   sdpi_device sdpi_device_i (.clk(clk), .rst(rst), .link(link_i), .leveling_active(lev), .calibrated(cal),
      .ready_normal(rdy), .array_writes(aw));
   sdpi_init_assertions #(.CKE_POST_CYC(8)) sdpi_init_assertions_i (.clk(clk), .rst(rst), .reset_n(link_i.reset_n),
      .cke(link_i.cke), .cs(link_i.cs), .ck_run(link_i.ck_run), .cmd(link_i.cmd), .dq_dev_oe(link_i.dq_dev_oe));
   initial begin
      forever #50 clk = ~clk;
   end
   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) begin sw_write <= 1'b1; sw_addr <= a; sw_wdata <= d; end
      @(posedge clk) sw_write <= 1'b0;
   endtask : wr
   // read, data taken in the cycle after the strobe
   task automatic rdx(input logic [3:0] a);
      @(posedge clk) begin sw_read <= 1'b1; sw_addr <= a; end
      @(posedge clk) sw_read <= 1'b0;
      #1 rd = sw_rdata;
   endtask : rdx
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin n_errors++; $display("[ERR] %s expected %h seen %h", n, e, g); end
   endtask : chk
   // poll status until the sequencer step shows up, bounded
   task automatic wait_step(input logic [3:0] s);
      for (int i = 0; i < 300; i++) begin
         rdx(`SDPI_CTL_STATUS);
         if (rd[3:0] === s) return;
      end
      chk("step wait", {4'h0, s}, rd);
      tally_and_finish();
   endtask : wait_step
   task automatic cmd_wait(input logic [7:0] c);
      wr(`SDPI_CTL_MRW, c);
      repeat (4) @(posedge clk);
   endtask : cmd_wait
   task automatic tally_and_finish();
      if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      chk("dq idle in reset", 8'h00, link_i.dq_dev_oe);
      wait_step(4'h4);
      chk("cke up", 8'h01, link_i.cke);
      chk("cs low", 8'h00, link_i.cs);
      chk("leveling default", 8'h00, lev);
      chk("not calibrated", 8'h00, cal);
      rdx(4'hf);
      chk("unmapped read", 8'h00, rd);
      wr(`SDPI_CTL_MRW, 8'h03);
      wait_step(4'h7);
      chk("calibrated", 8'h01, cal);
      wr(`SDPI_CTL_MRR_ADDR, {2'b00, `SDPI_MA_CMD_REF});
      cmd_wait(8'h02);
      rdx(`SDPI_CTL_MRR_DATA);
      chk("cmd ref default", `SDPI_REF_LEVEL_RST, rd);
      wr(`SDPI_CTL_MRR_ADDR, {2'b00, `SDPI_MA_LATENCY_TWO});
      wr(`SDPI_CTL_TRAIN_PAT, 8'h80);
      cmd_wait(8'h80);
      chk("leveling on", 8'h01, lev);
      wr(`SDPI_CTL_MRR_ADDR, 8'h2d);
      cmd_wait(8'h05);
      rdx(`SDPI_CTL_MRR_DATA);
      chk("bus training echo", 8'h2d, rd);
      cmd_wait(8'h06);
      rdx(`SDPI_CTL_MRR_DATA);
      chk("read calibration", `SDPI_TRAIN_PATTERN, rd);
      chk("array untouched", 8'h00, aw);
      cmd_wait(8'h07);
      chk("ready normal", 8'h01, rdy);
      chk("array count", 8'h01, aw);
      wr(`SDPI_CTL_CONTROL, 8'h01);
      repeat (3) @(posedge clk);
      chk("leveling cleared", 8'h00, lev);
      chk("cke low again", 8'h00, link_i.cke);
      wait_step(4'h4);
      chk("leveling default again", 8'h00, lev);
      tally_and_finish();
   end
endmodule : testbench
